// ===== inc/tdmtx_pkg.sv
// Constants shared by the time-slot transmit mode control block
package tdmtx_pkg;

  // ************************************************************
  // Channel mode word layout (bit 15 is the framing select)
  // ************************************************************
  localparam int unsigned  TDMTX_MODE_B    = 15;
  localparam int unsigned  TDMTX_IDLE_B    = 13;
  localparam int unsigned  TDMTX_TXON_B    = 12;
  localparam int unsigned  TDMTX_POLL_B    = 8;
  localparam int unsigned  TDMTX_CRC_B     = 7;
  localparam int unsigned  TDMTX_NOF_LSB   = 0;
  localparam int unsigned  TDMTX_NOF_W     = 4;
  localparam logic [15:0]  TDMTX_WMASK     = 16'hB18F;
  localparam logic [15:0]  TDMTX_MODE_RST  = 16'h0000;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [31:0]  TDMTX_CHMODE_BASE = 32'h0000_0000;
  localparam int unsigned  TDMTX_NCH_DEF     = 32;
  localparam int unsigned  TDMTX_AW_DEF      = 8;

  // ************************************************************
  // Line patterns and CRC
  // ************************************************************
  localparam logic [7:0]   TDMTX_FLAG      = 8'h7E;
  localparam logic [7:0]   TDMTX_ONES      = 8'hFF;
  localparam logic [15:0]  TDMTX_POLY16    = 16'h8408;
  localparam logic [31:0]  TDMTX_POLY32    = 32'hEDB8_8320;
  localparam logic [31:0]  TDMTX_CRC_INIT  = 32'hFFFF_FFFF;
  localparam logic [3:0]   TDMTX_CRC16_END = 4'h1;
  localparam logic [3:0]   TDMTX_CRC32_END = 4'h3;

  // ************************************************************
  // Per-channel transmit engine states
  // ************************************************************
  typedef enum logic [2:0] {
    TDMTX_ST_UNINIT = 3'b000,
    TDMTX_ST_IDLE   = 3'b001,
    TDMTX_ST_FLAG   = 3'b010,
    TDMTX_ST_DATA   = 3'b011,
    TDMTX_ST_CRC    = 3'b100,
    TDMTX_ST_CLOSE  = 3'b101,
    TDMTX_ST_XPAR   = 3'b110
  } tdmtx_st_t;

endpackage : tdmtx_pkg

// ===== design/tdmtx_mode_ctrl.sv
// Per-channel transmit mode control for a time-slot multiplexed serial line
//
// What this block does
// - Top mode bit picks transparent (0) or HDLC (1) per channel.
// - No idle fill: no idle bytes, count plus one flags, then data.
// - No idle fill and no buffer ready: keep sending flags.
// - Flag count zero without idle fill shares one flag between frames.
// - Extra flags may appear when buffers arrive late.
// - Idle fill: at least one idle byte, then count plus one flags.
// - Idle fill startup sends all-ones init, all-ones idle, flags, data.
// - Transmit off: the channel's slots carry all ones.
// - Transmit on: channel sends per its framing and settings.
// - Descriptor ready flags are checked only while scanning is enabled.
// - Device clears scan enable on finding a descriptor not ready.
// - CRC select 0 gives 16-bit CRC, 1 gives 32-bit CRC.
// - Low nibble sets minimum flags; one flag always precedes first frame.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module tdmtx_mode_ctrl
  import tdmtx_pkg::*;
#(
  parameter int unsigned NCH = TDMTX_NCH_DEF,
  parameter int unsigned AW  = TDMTX_AW_DEF,
  parameter int unsigned CW  = (NCH > 1) ? $clog2(NCH) : 1
) (
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          slot_req,
  input  wire logic [CW-1:0] slot_ch,
  input  wire logic          bd_ready,
  input  wire logic [7:0]    bd_byte,
  input  wire logic          bd_last,
  output logic      [7:0]    tx_byte,
  output logic               tx_valid,
  output logic      [CW-1:0] tx_ch,
  output logic               bd_check,
  output logic               bd_take
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [NCH-1:0][15:0] mode;
    tdmtx_st_t [NCH-1:0]  st;
    logic [NCH-1:0][3:0]  cnt;
    logic [NCH-1:0][31:0] crc;
    logic                 ack;
    logic [31:0]          rdat;
    logic [7:0]           txb;
    logic                 txv;
    logic [CW-1:0]        bch;
    logic                 chk;
    logic                 take;
  } tdmtx_state_t;

  tdmtx_state_t s_r;
  tdmtx_state_t s_nxt;
  logic         rst_meta_r;
  logic         rst_n_r;

  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ************************************************************
  // Bitwise reflected CRC over one byte
  // ************************************************************
  function automatic logic [31:0] tdmtx_crc_byte(
    input logic [31:0] cin,
    input logic [7:0]  d,
    input logic        wide
  );
    logic [31:0] c;
    logic        fb;
    c  = cin;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      if (wide) begin
        c = {1'b0, c[31:1]} ^ (fb ? TDMTX_POLY32 : 32'h0000_0000);
      end else begin
        c = {16'h0000, 1'b0, c[15:1]} ^ {16'h0000, (fb ? TDMTX_POLY16 : 16'h0000)};
      end
    end
    return c;
  endfunction : tdmtx_crc_byte

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [CW-1:0]         c;
    logic [15:0]           m;
    logic [TDMTX_NOF_W-1:0] min_flag_count;
    logic                  rdy;
    logic                  look;
    logic [3:0]            crc_end;
    logic [AW-3:0]         idx;
    logic                  hit;
    logic [CW-1:0]         ci;
    c       = slot_ch;
    m       = s_r.mode[c];
    min_flag_count     = m[TDMTX_NOF_LSB +: TDMTX_NOF_W];
    rdy     = m[TDMTX_POLL_B] & bd_ready;
    look    = 1'b0;
    crc_end = m[TDMTX_CRC_B] ? TDMTX_CRC32_END : TDMTX_CRC16_END;
    idx     = wb_adr_i[AW-1:2];
    hit     = ({{(32-AW+2){1'b0}}, idx} < NCH);
    ci      = idx[CW-1:0];

    s_nxt      = s_r;
    s_nxt.ack  = 1'b0;
    s_nxt.txv  = 1'b0;
    s_nxt.chk  = 1'b0;
    s_nxt.take = 1'b0;

    if (slot_req) begin
      s_nxt.txv = 1'b1;
      s_nxt.bch = c;
      s_nxt.txb = TDMTX_ONES;
      if (!m[TDMTX_TXON_B]) begin
        // Disabled transmitter restarts as uninitialised on re-enable
        s_nxt.st[c] = TDMTX_ST_UNINIT;
      end else begin
        case (s_r.st[c])
          TDMTX_ST_UNINIT: begin
            s_nxt.txb = TDMTX_ONES;
            if (!m[TDMTX_MODE_B]) begin
              s_nxt.st[c] = TDMTX_ST_XPAR;
            end else if (m[TDMTX_IDLE_B]) begin
              s_nxt.st[c] = TDMTX_ST_IDLE;
            end else begin
              s_nxt.st[c]  = TDMTX_ST_FLAG;
              s_nxt.cnt[c] = 4'(min_flag_count);
            end
          end
          TDMTX_ST_IDLE: begin
            // One idle byte always goes out before the flags
            s_nxt.txb = TDMTX_ONES;
            look      = 1'b1;
            if (rdy) begin
              s_nxt.st[c]  = TDMTX_ST_FLAG;
              s_nxt.cnt[c] = 4'(min_flag_count);
            end
          end
          TDMTX_ST_FLAG: begin
            s_nxt.txb = TDMTX_FLAG;
            if (s_r.cnt[c] != 4'h0) begin
              s_nxt.cnt[c] = s_r.cnt[c] - 4'h1;
            end else begin
              look = 1'b1;
              // Late buffers stretch the flag run and clear scan enable until software sets it again
              if (rdy) begin
                s_nxt.st[c]  = TDMTX_ST_DATA;
                s_nxt.crc[c] = TDMTX_CRC_INIT;
              end
            end
          end
          TDMTX_ST_DATA: begin
            s_nxt.txb    = bd_byte;
            s_nxt.take   = 1'b1;
            s_nxt.crc[c] = tdmtx_crc_byte(s_r.crc[c], bd_byte, m[TDMTX_CRC_B]);
            if (bd_last) begin
              s_nxt.st[c]  = TDMTX_ST_CRC;
              s_nxt.cnt[c] = 4'h0;
            end
          end
          TDMTX_ST_CRC: begin
            // Complemented CRC, low byte first
            s_nxt.txb    = ~s_r.crc[c][{s_r.cnt[c][1:0], 3'b000} +: 8];
            s_nxt.cnt[c] = s_r.cnt[c] + 4'h1;
            if (s_r.cnt[c] >= crc_end) begin
              if (m[TDMTX_IDLE_B]) begin
                s_nxt.st[c] = TDMTX_ST_CLOSE;
              end else begin
                // First flag of the next run closes this frame
                s_nxt.st[c]  = TDMTX_ST_FLAG;
                s_nxt.cnt[c] = 4'(min_flag_count);
              end
            end
          end
          TDMTX_ST_CLOSE: begin
            s_nxt.txb   = TDMTX_FLAG;
            s_nxt.st[c] = TDMTX_ST_IDLE;
          end
          TDMTX_ST_XPAR: begin
            look = 1'b1;
            if (rdy) begin
              s_nxt.txb  = bd_byte;
              s_nxt.take = 1'b1;
            end
            if (m[TDMTX_MODE_B]) begin
              s_nxt.st[c] = TDMTX_ST_UNINIT;
            end
          end
          default: begin
            s_nxt.st[c] = TDMTX_ST_UNINIT;
          end
        endcase
      end
      if (look && m[TDMTX_POLL_B]) begin
        s_nxt.chk = 1'b1;
        if (!bd_ready) begin
          s_nxt.mode[c][TDMTX_POLL_B] = 1'b0;
        end
      end
    end

    // Wishbone slave: answer one cycle after the request, write on the ack edge
    if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
      s_nxt.ack  = 1'b1;
      s_nxt.rdat = hit ? {16'h0000, s_r.mode[ci]} : 32'h0000_0000;
    end
    if (wb_cyc_i && wb_stb_i && s_r.ack && wb_we_i && hit) begin
      // Applied after the engine so a software set beats a hardware clear
      if (wb_sel_i[0]) begin
        s_nxt.mode[ci][7:0] = wb_dat_i[7:0] & TDMTX_WMASK[7:0];
      end
      if (wb_sel_i[1]) begin
        s_nxt.mode[ci][15:8] = wb_dat_i[15:8] & TDMTX_WMASK[15:8];
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign tx_byte  = s_r.txb;
  assign tx_valid = s_r.txv;
  assign tx_ch    = s_r.bch;
  assign bd_check = s_r.chk;
  assign bd_take  = s_r.take;

endmodule : tdmtx_mode_ctrl

// ===== dv/tdmtx_mode_ctrl_asserts.sv
// Port-level checks for the transmit mode control block
`timescale 1ns/1ps
module tdmtx_mode_ctrl_asserts
  import tdmtx_pkg::*;
#(
  parameter int unsigned NCH = TDMTX_NCH_DEF,
  parameter int unsigned AW  = TDMTX_AW_DEF,
  parameter int unsigned CW  = 5
) (
  input wire logic          ref_clk,
  input wire logic          arst_n,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic          slot_req,
  input wire logic [CW-1:0] slot_ch,
  input wire logic          bd_ready,
  input wire logic [7:0]    bd_byte,
  input wire logic          bd_last,
  input wire logic [7:0]    tx_byte,
  input wire logic          tx_valid,
  input wire logic [CW-1:0] tx_ch,
  input wire logic          bd_check,
  input wire logic          bd_take
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RSVD_ZERO: assert property (wb_ack_o |-> (wb_dat_o & ~{16'h0000, TDMTX_WMASK}) == 0)
    else $error("reserved bits read back");
  AST_SLOT_ANS: assert property (slot_req |=> tx_valid && tx_ch == $past(slot_ch))
    else $error("slot unanswered");
  AST_NO_SLOT: assert property (!slot_req |=> !tx_valid && !bd_take) else $error("spurious byte");
  AST_TAKE_BYTE: assert property (bd_take |-> tx_byte == $past(bd_byte) && $past(bd_ready))
    else $error("frame byte wrong");
  AST_CHECK_SLOT: assert property (bd_check |-> tx_valid) else $error("check outside slot");
endmodule : tdmtx_mode_ctrl_asserts

bind tdmtx_mode_ctrl tdmtx_mode_ctrl_asserts #(.NCH(NCH), .AW(AW), .CW(CW)) u_chk (.*);

// ===== dv/tdmtx_slot_model.sv
// Slot assigner and descriptor memory stand-in on the serial side
`timescale 1ns/1ps
module tdmtx_slot_model #(
  parameter int unsigned CW = 5
) (
  input  wire logic          ref_clk,
  input  wire logic          en,
  input  wire logic [CW-1:0] ch,
  input  wire logic          rdy,
  input  wire logic          bd_take,
  output logic               slot_req,
  output logic      [CW-1:0] slot_ch,
  output logic               bd_ready,
  output logic      [7:0]    bd_byte,
  output logic               bd_last
);
  logic [7:0] cnt_r = 8'h10;
  // Every other cycle, so a take lands before the next slot samples
  always_ff @(posedge ref_clk) begin
    slot_req <= en & ~slot_req;
    slot_ch  <= ch;
    if (bd_take) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign bd_ready = rdy;
  // Not ready: no stale data left on the byte lines
  assign bd_byte  = rdy ? cnt_r : ~cnt_r;
  assign bd_last  = 1'b0;
endmodule : tdmtx_slot_model

// ===== dv/tb.sv
// Self-checking bench for the transmit mode control block
`timescale 1ns/1ps
module tb;
  import tdmtx_pkg::*;
  logic        ref_clk = 0, arst_n = 0, req = 0, wb_we_i = 0, en = 0, rdy = 0;
  logic [7:0]  wb_adr_i = '0, b, d0, bd_byte, tx_byte;
  logic [3:0]  wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = '0, rd, wb_dat_o;
  logic [4:0]  ch = '0, slot_ch, tx_ch;
  logic        wb_ack_o, slot_req, bd_ready, bd_last, tx_valid, bd_check, bd_take;
  int          miscompares = 0, checks_done = 0, n;

  tdmtx_mode_ctrl i_dut (.*, .wb_cyc_i(req), .wb_stb_i(req));
  tdmtx_slot_model i_pm (.*);

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic hang;
    miscompares++;
    print_verdict();
  endtask : hang
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    // Ack is sampled on the rising edge; write and read data land there
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 8);
    if (wb_ack_o !== 1'b1) hang();
    rd = wb_dat_o;
    req <= 1'b0;
  endtask : wb
  task automatic rx(output logic [7:0] v);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (tx_valid !== 1'b1 && n < 8);
    if (tx_valid !== 1'b1) hang();
    check(tx_ch, ch);
    v = tx_byte;
  endtask : rx
  task automatic sel(input logic [4:0] c, input logic r);
    @(posedge ref_clk);
    ch <= c;
    rdy <= r;
    en <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : sel
  // Leading ones, f flags, then two frame bytes
  task automatic go(input logic [7:0] a, input logic [31:0] m, input int f);
    int k;
    @(negedge ref_clk);
    d0 = bd_byte;
    wb(1'b1, a, m);
    rx(b);
    for (k = 0; b === 8'hFF && k < 40; k++) rx(b);
    check(k > 0, 1'b1);
    for (int i = 0; i < f; i++) begin
      check(b, 8'h7E);
      rx(b);
    end
    check(b, d0);
    rx(b);
    check(b, d0 + 8'h01);
  endtask : go
  task automatic t_regs;
    wb(1'b1, 8'h04, 32'hFFFF_FFFF);
    wb(1'b0, 8'h04, 32'h0000_0000);
    check(rd, 32'h0000_B18F);
    wb(1'b0, 8'h00, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wb(1'b1, 8'h80, 32'h0000_9101);
    wb(1'b0, 8'h80, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_idle;
    sel(5'd5, 1'b0);
    wb(1'b1, 8'h14, 32'h0000_B101);
    for (int i = 0; i < 6; i++) begin
      rx(b);
      check(b, 8'hFF);
    end
    // Bench never writes scan enable low; only the block clears it
    wb(1'b0, 8'h14, 32'h0000_0000);
    check(rd, 32'h0000_B001);
    @(posedge ref_clk);
    rdy <= 1'b1;
    go(8'h14, 32'h0000_B101, 2);
    $display("test idle done");
  endtask : t_idle

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_regs();
    sel(5'd0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rx(b);
      check(b, 8'hFF);
    end
    $display("test off done");
    // Descriptors carry no pad, so any flag count meets it
    sel(5'd2, 1'b1);
    go(8'h08, 32'h0000_9101, 2);
    sel(5'd3, 1'b1);
    go(8'h0C, 32'h0000_9100, 1);
    sel(5'd6, 1'b1);
    go(8'h18, 32'h0000_918F, 16);
    sel(5'd4, 1'b1);
    go(8'h10, 32'h0000_1100, 0);
    // Receiver state words live outside this block; nothing to load here
    $display("test framing done");
    t_idle();
    print_verdict();
  end
endmodule : tb
